//--- hbp_pkg.sv
// Package for the H-bridge PWM output stage: register map, field layout,
// reset values and shared types.
// Assumes a 32-bit Avalon-MM byte address bus; offsets are full byte addresses.
package hbp_pkg;

  // Register byte addresses
  localparam logic [31:0] HBP_MAIN_CTRL_ADDR  = 32'hFFFF0F80;
  localparam logic [31:0] HBP_P0_CMP_A_ADDR   = 32'hFFFF0F84;
  localparam logic [31:0] HBP_P0_CMP_B_ADDR   = 32'hFFFF0F88;
  localparam logic [31:0] HBP_P0_CMP_C_ADDR   = 32'hFFFF0F8C;
  localparam logic [31:0] HBP_P1_CMP_A_ADDR   = 32'hFFFF0F94;
  localparam logic [31:0] HBP_P1_CMP_B_ADDR   = 32'hFFFF0F98;
  localparam logic [31:0] HBP_P1_CMP_C_ADDR   = 32'hFFFF0F9C;
  localparam logic [31:0] HBP_P2_CMP_A_ADDR   = 32'hFFFF0FA4;
  localparam logic [31:0] HBP_P2_CMP_B_ADDR   = 32'hFFFF0FA8;
  localparam logic [31:0] HBP_P2_CMP_C_ADDR   = 32'hFFFF0FAC;
  localparam logic [31:0] HBP_ADC_CTRL_ADDR   = 32'hFFFF0FB4;
  localparam logic [31:0] HBP_TRIP_CLR_ADDR   = 32'hFFFF0FB8;
  localparam logic [31:0] HBP_IRQ_STAT_ADDR   = 32'hFFFF0FBC;
  localparam logic [31:0] HBP_IRQ_MASK_ADDR   = 32'hFFFF0FC0;
  localparam logic [31:0] HBP_PIN_FUNC_ADDR   = 32'hFFFF0FC4;

  // Reset values
  localparam logic [15:0] HBP_MAIN_CTRL_RST   = 16'h0012;
  localparam logic [15:0] HBP_CMP_RST         = 16'h0000;
  localparam logic [7:0]  HBP_ADC_CTRL_RST    = 8'h00;
  localparam logic [3:0]  HBP_PIN_FUNC_RST    = 4'hF;

  // Writable bit masks; other bits read as zero
  localparam logic [15:0] HBP_MAIN_CTRL_WMASK = 16'h063F;
  localparam logic [7:0]  HBP_ADC_CTRL_WMASK  = 8'h8F;

  // Main control field positions
  localparam int HBP_MASTER_EN_BIT = 0;
  localparam int HBP_BRIDGE_BIT    = 1;
  localparam int HBP_DIR_BIT       = 2;
  localparam int HBP_LOAD_CMP_BIT  = 3;
  localparam int HBP_HS_OFF_BIT    = 4;
  localparam int HBP_INVERT_BIT    = 5;
  localparam int HBP_BR_EN_BIT     = 9;
  localparam int HBP_TRIP_EN_BIT   = 10;

  // Trigger control field positions
  localparam int HBP_TRIG_EN_BIT   = 7;
  localparam int HBP_TRIG_DLY_MSB  = 3;

  // Interrupt status bits
  localparam int HBP_IRQ_TRIP_BIT  = 0;
  localparam int HBP_IRQ_TRIG_BIT  = 1;
  localparam int HBP_IRQ_W         = 2;

  // Decoded main control fields
  typedef struct packed {
    logic master_output_enable;
    logic bridge_mode_select;
    logic dir;
    logic load_cmp;
    logic high_side_force_off;
    logic global_output_invert;
    logic bridge_output_enable;
    logic trip_interrupt_enable;
  } hbp_ctrl_t;

  // The four bridge outputs
  typedef struct packed {
    logic output_a;
    logic output_b;
    logic output_c;
    logic output_d;
  } hbp_outs_t;

  function automatic hbp_ctrl_t hbp_decode_ctrl(input logic [15:0] r);
    hbp_ctrl_t c;
    c.master_output_enable  = r[HBP_MASTER_EN_BIT];
    c.bridge_mode_select    = r[HBP_BRIDGE_BIT];
    c.dir                   = r[HBP_DIR_BIT];
    c.load_cmp              = r[HBP_LOAD_CMP_BIT];
    c.high_side_force_off   = r[HBP_HS_OFF_BIT];
    c.global_output_invert  = r[HBP_INVERT_BIT];
    c.bridge_output_enable  = r[HBP_BR_EN_BIT];
    c.trip_interrupt_enable = r[HBP_TRIP_EN_BIT];
    return c;
  endfunction

endpackage

//--- hbp_out_map.sv
// Output selection for H-bridge and standard operation.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module hbp_out_map (
  // Control and waveforms
  input  var hbp_pkg::hbp_ctrl_t ctrl_i,
  input  wire logic              high_side_waveform_i,
  input  wire logic              low_side_waveform_i,
  // Selected outputs
  output hbp_pkg::hbp_outs_t     outs_o
);
  import hbp_pkg::*;

  logic hs;
  logic ls;
  logic idle;

  // Master enable off starves the waveforms so the bridge sits idle
  assign hs   = high_side_waveform_i & ctrl_i.master_output_enable;
  assign ls   = low_side_waveform_i & ctrl_i.master_output_enable;
  assign idle = ctrl_i.global_output_invert;

  // Table order: standard mode first, then force-off, then disabled, then active pair
  always_comb begin
    if (!ctrl_i.bridge_mode_select) begin
      outs_o = '{hs, ls, hs, ls};
    end else if (ctrl_i.high_side_force_off) begin
      outs_o = '{1'b1, 1'b0, 1'b1, 1'b0};
    end else if (!ctrl_i.bridge_output_enable) begin
      outs_o = '{1'b1, 1'b1, 1'b1, 1'b1};
    end else if (ctrl_i.dir ^ ctrl_i.global_output_invert) begin
      outs_o = '{hs, ls, idle, idle};
    end else begin
      outs_o = '{idle, idle, hs, ls};
    end
  end

endmodule

//--- hbp_adc_trig.sv
// Delayed ADC convert trigger taken from the low-side waveform.
// Assumes low_side_i and adc_tick_i are on clock_i; adc_tick_i marks ADC clock edges.
`timescale 1ns/1ps
module hbp_adc_trig (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       enable_i,
  input  wire logic [3:0] delay_code_i,
  input  wire logic       low_side_i,
  input  wire logic       adc_tick_i,
  // Results
  output logic            trigger_o,
  output logic            conv_start_o
);
  import hbp_pkg::*;

  typedef enum logic [1:0] {HBP_T_IDLE, HBP_T_DELAY, HBP_T_PASS} hbp_tstate_t;

  hbp_tstate_t state_r;
  logic [5:0]  cnt_r;
  logic        ls_r;
  logic        pend_r;
  logic        rise;

  assign rise = low_side_i & ~ls_r;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) ls_r <= 1'b0;
    else          ls_r <= low_side_i;
  end

  // Delay runs 4*(code+1) cycles; pulse too short aborts silently
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r <= HBP_T_IDLE;
      cnt_r   <= 6'h00;
    end else begin
      case (state_r)
        HBP_T_IDLE: if (enable_i && rise) begin
          cnt_r   <= {delay_code_i, 2'b00} + 6'h03;
          state_r <= HBP_T_DELAY;
        end
        HBP_T_DELAY: if (!low_side_i || !enable_i) begin
          state_r <= HBP_T_IDLE;
        end else if (cnt_r == 6'h00) begin
          state_r <= HBP_T_PASS;
        end else begin
          cnt_r <= cnt_r - 6'h01;
        end
        HBP_T_PASS: state_r <= HBP_T_IDLE;
        default:    state_r <= HBP_T_IDLE;
      endcase
    end
  end

  // Trigger one cycle after expiry; conversion waits for the next ADC edge
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trigger_o    <= 1'b0;
      pend_r       <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      trigger_o    <= (state_r == HBP_T_PASS);
      pend_r       <= (pend_r | trigger_o) & ~adc_tick_i;
      conv_start_o <= (pend_r | trigger_o) & adc_tick_i;
    end
  end

  property p_trig_needs_enable;
    @(posedge clock_i) disable iff (!rst_n_i)
      trigger_o |-> $past(enable_i, 2);
  endproperty
  a_trig_needs_enable: assert property (p_trig_needs_enable)
    else $error("trigger issued while disabled");

  property p_short_pulse_abort;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_r == HBP_T_DELAY && !low_side_i) |=> ##1 !trigger_o;
  endproperty
  a_short_pulse_abort: assert property (p_short_pulse_abort)
    else $error("trigger after low side ended early");

  property p_min_delay;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_r == HBP_T_IDLE && enable_i && rise) |=> !trigger_o [*5];
  endproperty
  a_min_delay: assert property (p_min_delay)
    else $error("trigger came before least delay");

endmodule

//--- hbp_top.sv
// H-bridge PWM output stage with compare registers, trip handling
// and delayed ADC convert trigger, reached over Avalon-MM.
// Assumes one clock; trip pin is asynchronous and is synchronised here.
// How it works
// - Disabled bridge drives all high; force-off fixes pattern
// - Direction and invert choose active pair
// - Main control resets to 0x12
// - Pins default to PWM function after reset
// - Nine compare registers, reset zero, feed compare stage
// - Any write to trip clear drops trip
// - Trigger follows low-side rise after delay
// - Trigger enable bit seven gates trigger
// - Delay equals four times code plus one
// - Delay longer than pulse gives no trigger
// - One extra cycle passes trigger onward
// - Conversion starts on next ADC clock edge
// - Bit one selects bridge mode and its controls
// - Trip input low clears master enable, interrupts
`timescale 1ns/1ps
module hbp_top (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  // Avalon-MM slave
  input  wire logic [31:0]        avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // Trip pin and ADC side
  input  wire logic               trip_pin_i,
  input  wire logic               adc_tick_i,
  output logic                    adc_convert_trigger_o,
  output logic                    adc_conv_start_o,
  // Bridge outputs and pin control
  output hbp_pkg::hbp_outs_t      outs_o,
  output logic [3:0]              pin_oe_n_o,
  output logic [3:0]              pin_pwm_func_o,
  output logic [15:0]             cmp_active_o [9],
  output logic                    irq_o
);
  import hbp_pkg::*;

  localparam logic [31:0] CMP_ADDR [9] = '{
    HBP_P0_CMP_A_ADDR, HBP_P0_CMP_B_ADDR, HBP_P0_CMP_C_ADDR,
    HBP_P1_CMP_A_ADDR, HBP_P1_CMP_B_ADDR, HBP_P1_CMP_C_ADDR,
    HBP_P2_CMP_A_ADDR, HBP_P2_CMP_B_ADDR, HBP_P2_CMP_C_ADDR};

  // Byte-enable merge used by the main control and compare registers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  logic [15:0]         main_ctrl_r;
  logic [15:0]         main_ctrl_nxt;
  logic [15:0]         cmp_r [9];
  logic [7:0]          adc_ctrl_r;
  logic [HBP_IRQ_W-1:0] irq_stat_r;
  logic [HBP_IRQ_W-1:0] irq_mask_r;
  logic [3:0]          pin_func_r;
  logic                ack_r;
  logic                req;
  logic                wr_go;
  logic [2:0]          trip_sync_r;
  logic                trip_lvl_r;
  logic                trip_hit;
  logic [15:0]         tmr_r;
  logic                hs_wave;
  logic                ls_wave;
  logic                trig;
  logic                trip_clr;
  hbp_ctrl_t           ctrl;
  hbp_outs_t           outs_nxt;

  assign ctrl = hbp_decode_ctrl(main_ctrl_r);

  // Fixed one wait state: first cycle stalls, second completes
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_go             = avs_write_i & ack_r;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) ack_r <= 1'b0;
    else          ack_r <= req & ~ack_r;
  end

  // Read data prepared during the wait state; unmapped reads give zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_r) begin
      avs_readdata_o <= 32'h00000000;
      for (int i = 0; i < 9; i++) begin
        if (avs_address_i == CMP_ADDR[i]) avs_readdata_o <= {16'h0000, cmp_r[i]};
      end
      case (avs_address_i)
        HBP_MAIN_CTRL_ADDR: avs_readdata_o <= {16'h0000, main_ctrl_r};
        HBP_ADC_CTRL_ADDR:  avs_readdata_o <= {24'h000000, adc_ctrl_r};
        HBP_IRQ_STAT_ADDR:  avs_readdata_o <= {30'h00000000, irq_stat_r};
        HBP_IRQ_MASK_ADDR:  avs_readdata_o <= {30'h00000000, irq_mask_r};
        HBP_PIN_FUNC_ADDR:  avs_readdata_o <= {28'h0000000, pin_func_r};
        default:            ;
      endcase
    end
  end

  // Trip pin: three flops, accepted once the last two agree
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trip_sync_r <= 3'h7;
      trip_lvl_r  <= 1'b1;
    end else begin
      trip_sync_r <= {trip_sync_r[1:0], trip_pin_i};
      if (trip_sync_r[1] == trip_sync_r[2]) trip_lvl_r <= trip_sync_r[2];
    end
  end

  assign trip_hit = ctrl.trip_interrupt_enable & ~trip_lvl_r;

  // Main control: trip forces master enable off over a software write
  always_comb begin
    main_ctrl_nxt = main_ctrl_r;
    if (wr_go && avs_address_i == HBP_MAIN_CTRL_ADDR) begin
      main_ctrl_nxt = 16'(be_merge({16'h0000, main_ctrl_r}, avs_writedata_i,
                                   avs_byteenable_i)) & HBP_MAIN_CTRL_WMASK;
    end
    if (trip_hit) main_ctrl_nxt[HBP_MASTER_EN_BIT] = 1'b0;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) main_ctrl_r <= HBP_MAIN_CTRL_RST;
    else          main_ctrl_r <= main_ctrl_nxt;
  end

  // Compare registers
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 9; i++) begin
      if (!rst_n_i) begin
        cmp_r[i] <= HBP_CMP_RST;
      end else if (wr_go && avs_address_i == CMP_ADDR[i]) begin
        cmp_r[i] <= 16'(be_merge({16'h0000, cmp_r[i]}, avs_writedata_i,
                                 avs_byteenable_i));
      end
    end
  end

  // Trigger control, pin function, interrupt mask
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      adc_ctrl_r <= HBP_ADC_CTRL_RST;
      pin_func_r <= HBP_PIN_FUNC_RST;
      irq_mask_r <= '0;
    end else if (wr_go && avs_byteenable_i[0]) begin
      case (avs_address_i)
        HBP_ADC_CTRL_ADDR: adc_ctrl_r <= avs_writedata_i[7:0] & HBP_ADC_CTRL_WMASK;
        HBP_PIN_FUNC_ADDR: pin_func_r <= avs_writedata_i[3:0];
        HBP_IRQ_MASK_ADDR: irq_mask_r <= avs_writedata_i[HBP_IRQ_W-1:0];
        default:           ;
      endcase
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  assign trip_clr = wr_go && avs_address_i == HBP_TRIP_CLR_ADDR;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= '0;
    end else begin
      for (int i = 0; i < HBP_IRQ_W; i++) begin
        if (wr_go && avs_address_i == HBP_IRQ_STAT_ADDR &&
            avs_byteenable_i[0] && avs_writedata_i[i]) irq_stat_r[i] <= 1'b0;
      end
      if (trip_clr) irq_stat_r[HBP_IRQ_TRIP_BIT] <= 1'b0;
      if (trip_hit) irq_stat_r[HBP_IRQ_TRIP_BIT] <= 1'b1;
      if (trig)     irq_stat_r[HBP_IRQ_TRIG_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) irq_o <= 1'b0;
    else          irq_o <= |(irq_stat_r & irq_mask_r);
  end

  // Pair-0 timer: period from compare c, high side below a, low side from b
  always_ff @(posedge clock_i) begin
    if (!rst_n_i)                          tmr_r <= 16'h0000;
    else if (tmr_r >= cmp_active_o[2])     tmr_r <= 16'h0000;
    else                                   tmr_r <= tmr_r + 16'h0001;
  end

  assign hs_wave = tmr_r < cmp_active_o[0];
  assign ls_wave = tmr_r >= cmp_active_o[1];

  // Compare stage reloads on the timer's 0 to 1 step when loading is enabled;
  // outside bridge mode the load bit is inert, so values reload freely
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 9; i++) begin
      if (!rst_n_i) begin
        cmp_active_o[i] <= HBP_CMP_RST;
      end else if (tmr_r == 16'h0000 &&
                   (ctrl.load_cmp || !ctrl.bridge_mode_select)) begin
        cmp_active_o[i] <= cmp_r[i];
      end
    end
  end

  hbp_out_map u_map (
    .ctrl_i               (ctrl),
    .high_side_waveform_i (hs_wave),
    .low_side_waveform_i  (ls_wave),
    .outs_o               (outs_nxt)
  );

  // Registered bridge outputs and pin enables
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      outs_o     <= '{1'b1, 1'b0, 1'b1, 1'b0};
      pin_oe_n_o <= 4'h0;
    end else begin
      outs_o     <= outs_nxt;
      pin_oe_n_o <= ~pin_func_r;
    end
  end

  assign pin_pwm_func_o = pin_func_r;

  hbp_adc_trig u_trig (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .enable_i     (adc_ctrl_r[HBP_TRIG_EN_BIT]),
    .delay_code_i (adc_ctrl_r[HBP_TRIG_DLY_MSB:0]),
    .low_side_i   (ls_wave & ctrl.master_output_enable),
    .adc_tick_i   (adc_tick_i),
    .trigger_o    (trig),
    .conv_start_o (adc_conv_start_o)
  );

  assign adc_convert_trigger_o = trig;

  property p_force_off;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ctrl.bridge_mode_select && ctrl.high_side_force_off)
        |=> outs_o == 4'hA;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("force-off pattern wrong");

  property p_disabled_high;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ctrl.bridge_mode_select && !ctrl.high_side_force_off &&
       !ctrl.bridge_output_enable) |=> outs_o == 4'hF;
  endproperty
  a_disabled_high: assert property (p_disabled_high)
    else $error("disabled bridge not all high");

  property p_idle_pair;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ctrl.bridge_mode_select && !ctrl.high_side_force_off &&
       ctrl.bridge_output_enable && ctrl.dir && !ctrl.global_output_invert)
        |=> !outs_o.output_c && !outs_o.output_d;
  endproperty
  a_idle_pair: assert property (p_idle_pair)
    else $error("idle pair not low");

  property p_reset_ctrl;
    @(posedge clock_i) $rose(rst_n_i) |-> main_ctrl_r == HBP_MAIN_CTRL_RST;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl)
    else $error("main control reset value wrong");

  property p_trip_clear;
    @(posedge clock_i) disable iff (!rst_n_i)
      (trip_clr && !trip_hit) |=> !irq_stat_r[HBP_IRQ_TRIP_BIT];
  endproperty
  a_trip_clear: assert property (p_trip_clear)
    else $error("trip flag survived clear");

  property p_trip_action;
    @(posedge clock_i) disable iff (!rst_n_i)
      trip_hit |=> !ctrl.master_output_enable && irq_stat_r[HBP_IRQ_TRIP_BIT];
  endproperty
  a_trip_action: assert property (p_trip_action)
    else $error("trip did not stop outputs");

  property p_reserved_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
      adc_ctrl_r[6:4] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved trigger bits set");

  property p_pins_default;
    @(posedge clock_i) $rose(rst_n_i) |-> pin_func_r == HBP_PIN_FUNC_RST;
  endproperty
  a_pins_default: assert property (p_pins_default)
    else $error("pins not in PWM function after reset");

  // Inverted selection parks the unused pair high instead of low
  property p_idle_pair_inv;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ctrl.bridge_mode_select && !ctrl.high_side_force_off &&
       ctrl.bridge_output_enable && !ctrl.dir && ctrl.global_output_invert)
        |=> outs_o.output_c && outs_o.output_d;
  endproperty
  a_idle_pair_inv: assert property (p_idle_pair_inv)
    else $error("inverted idle pair not high");

  // Every new request stalls for exactly one cycle, then completes
  sequence s_req_new;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  property p_one_wait;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_req_new |=> !avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus request stalled more than one cycle");

  // Two agreeing low samples of the trip pin must lower the filtered level
  sequence s_trip_low;
    trip_sync_r[2:1] == 2'b00;
  endsequence
  property p_trip_filtered;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_trip_low |=> !trip_lvl_r;
  endproperty
  a_trip_filtered: assert property (p_trip_filtered)
    else $error("trip pin low not accepted");

  // Interrupt line follows unmasked status one cycle later
  property p_irq_level;
    @(posedge clock_i) disable iff (!rst_n_i)
      |(irq_stat_r & irq_mask_r) |=> irq_o;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked status did not raise interrupt");

  // A conversion start only ever follows an ADC clock edge
  property p_conv_on_tick;
    @(posedge clock_i) disable iff (!rst_n_i)
      adc_conv_start_o |-> $past(adc_tick_i);
  endproperty
  a_conv_on_tick: assert property (p_conv_on_tick)
    else $error("conversion start without ADC edge");

endmodule

//--- hbp_far_model.sv
// Far-side model: trip sensor pin and ADC clock-edge strobes.
// Assumes the bench clock; the trip pin has a pull-up, so it idles high.
`timescale 1ns/1ps
module hbp_far_model (
  // Clock and command
  input  wire logic clock_i,
  input  wire logic trip_req_i,
  // Toward the block
  output logic      trip_pin_o,
  output logic      adc_tick_o = 1'b0
);
  logic [2:0] div_r = 3'h0;
  // Fault pulls the pin low; otherwise the pull-up wins
  assign trip_pin_o = !trip_req_i;
  // ADC edge every eight cycles, so a start request must wait for it
  always_ff @(posedge clock_i) begin
    div_r      <= div_r + 3'h1;
    adc_tick_o <= (div_r == 3'h7);
  end
endmodule

//--- hbp_top_test.sv
// Self-checking bench for hbp_top: registers, bridge outputs, trip
// interrupt and ADC trigger timing. Assumes hbp_far_model beside it.
`timescale 1ns/1ps
module hbp_top_test;
  import hbp_pkg::*;
  logic        clock_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
  logic        trip_req = 0, avs_waitrequest_o, trip_pin, adc_tick;
  logic        trig_o, conv_o, irq_o;
  logic [31:0] avs_address_i = 0, avs_writedata_i = 0, avs_readdata_o;
  logic [31:0] rnd = 32'h86AED907;
  logic [3:0]  pin_oe_n, pin_fn;
  logic [15:0] cmp_act [9];
  hbp_outs_t   outs_o;
  logic [31:0] exp_q [$];
  logic [31:0] ca [9] = '{HBP_P0_CMP_A_ADDR, HBP_P0_CMP_B_ADDR, HBP_P0_CMP_C_ADDR,
    HBP_P1_CMP_A_ADDR, HBP_P1_CMP_B_ADDR, HBP_P1_CMP_C_ADDR,
    HBP_P2_CMP_A_ADDR, HBP_P2_CMP_B_ADDR, HBP_P2_CMP_C_ADDR};
  int error_cnt = 0, checks = 0;
  always #50 clock_i = ~clock_i;
  hbp_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .trip_pin_i(trip_pin), .adc_tick_i(adc_tick),
    .adc_convert_trigger_o(trig_o), .adc_conv_start_o(conv_o), .outs_o(outs_o),
    .pin_oe_n_o(pin_oe_n), .pin_pwm_func_o(pin_fn), .cmp_active_o(cmp_act), .irq_o(irq_o));
  hbp_far_model far (.clock_i(clock_i), .trip_req_i(trip_req), .trip_pin_o(trip_pin),
    .adc_tick_o(adc_tick));
  task automatic check(string what, logic [31:0] seen, logic [31:0] expv);
    checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  // One bus cycle; an edge passes first so a release never meets a new raise
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge clock_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clock_i);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Read data is taken at the edge where the wait ends, oldest note first
  always @(posedge clock_i)
    if (avs_read_i && avs_waitrequest_o === 1'b0)
      check("readdata", avs_readdata_o, exp_q.pop_front());
  // Waits for a fresh low-side rise, then for the trigger and the start
  task automatic meas(output int c, output logic cv);
    c = 0;
    cv = 0;
    repeat (402) @(posedge clock_i);
    while (outs_o.output_b !== 1'b0)
      @(posedge clock_i);
    while (outs_o.output_b !== 1'b1)
      @(posedge clock_i);
    while (trig_o !== 1'b1 && c < 100) begin
      c++;
      @(posedge clock_i);
    end
    if (c < 100)
      repeat (12) begin
        @(posedge clock_i);
        if (conv_o === 1'b1)
          cv = 1;
      end
  endtask
  initial begin
    #3ms;
    error_cnt++;
    complete_run();
  end
  // Main sequence
  initial begin
    int c, d;
    logic cv;
    logic [31:0] v;
    int bt [5] = '{100, 100, 190, 190, 100};
    int ct [5] = '{15, 0, 1, 2, 15};
    logic [4:0] et = 5'b01111, okt = 5'b00111;
    logic [3:0] ot [4] = '{4'h0, 4'h0, 4'h3, 4'hC};
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    check("outs_rst", outs_o, 4'hA);
    check("pin_oe", pin_oe_n, 4'h0);
    check("pin_fn", pin_fn, 4'hF);
    rd(HBP_MAIN_CTRL_ADDR, 32'h12);
    rd(HBP_ADC_CTRL_ADDR, 32'h0);
    rd(HBP_PIN_FUNC_ADDR, 32'hF);
    for (int i = 0; i < 9; i++) begin
      v = xs() & 32'hFFFF;
      rd(ca[i], 32'h0);
      bus(1'b1, ca[i], v);
      rd(ca[i], v);
    end
    bus(1'b1, 32'hFFFF0F90, xs());
    rd(32'hFFFF0F90, 32'h0);
    bus(1'b1, HBP_ADC_CTRL_ADDR, 32'hFF);
    rd(HBP_ADC_CTRL_ADDR, 32'h8F);
    bus(1'b1, HBP_MAIN_CTRL_ADDR, 32'h2);
    repeat (3) @(posedge clock_i);
    check("outs_off", outs_o, 4'hF);
    // Master enable off keeps both waveforms low, exposing the idle pair
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, HBP_MAIN_CTRL_ADDR, 32'h202 | (k[0] << 2) | (k[1] << 5));
      repeat (3) @(posedge clock_i);
      check("outs_map", outs_o, ot[k]);
    end
    bus(1'b1, HBP_MAIN_CTRL_ADDR, 32'h232);
    repeat (3) @(posedge clock_i);
    check("outs_hsoff", outs_o, 4'hA);
    bus(1'b1, ca[0], 32'd50);
    bus(1'b1, ca[2], 32'd200);
    bus(1'b1, HBP_MAIN_CTRL_ADDR, 32'h20F);
    for (int j = 0; j < 5; j++) begin
      bus(1'b1, ca[1], bt[j]);
      bus(1'b1, HBP_ADC_CTRL_ADDR, (et[j] << 7) | ct[j]);
      meas(c, cv);
      check("cmp_stage", cmp_act[1], bt[j]);
      d = 4 * (ct[j] + 1);
      if (okt[j]) begin
        check("trig_delay", 32'(c >= d && c <= d + 2), 32'h1);
        check("conv_start", cv, 1'b1);
      end else
        check("no_trig", c, 32'd100);
    end
    bus(1'b1, HBP_ADC_CTRL_ADDR, 32'h0);
    bus(1'b1, HBP_IRQ_MASK_ADDR, 32'h0);
    bus(1'b1, HBP_MAIN_CTRL_ADDR, 32'h60F);
    bus(1'b1, HBP_IRQ_STAT_ADDR, 32'h3);
    trip_req <= 1'b1;
    repeat (10) @(posedge clock_i);
    check("irq_masked", irq_o, 1'b0);
    rd(HBP_IRQ_STAT_ADDR, 32'h1);
    rd(HBP_MAIN_CTRL_ADDR, 32'h60E);
    bus(1'b1, HBP_IRQ_MASK_ADDR, 32'h1);
    repeat (3) @(posedge clock_i);
    check("irq_on", irq_o, 1'b1);
    trip_req <= 1'b0;
    repeat (8) @(posedge clock_i);
    bus(1'b1, HBP_TRIP_CLR_ADDR, xs());
    repeat (3) @(posedge clock_i);
    check("irq_clr", irq_o, 1'b0);
    rd(HBP_IRQ_STAT_ADDR, 32'h0);
    repeat (3) @(posedge clock_i);
    complete_run();
  end
endmodule
